// >>> hw/adcc_config_bank.v
// Software-mode configuration bank and conversion pair scheduler.
// Assumes command words arrive already assembled on the system clock;
// the conversion start pin is asynchronous and is synchronised here.
`timescale 1ns/1ps
`include "adcc_consts.vh"

module adcc_config_bank (
	input  wire        clock,           // System clock, 125 MHz
	input  wire        reset_n,         // Async reset, active low
	input  wire        cmd_valid,       // Command word strobe
	input  wire [15:0] cmd_word,        // Command word from the host port
	output reg  [15:0] rd_word_ff,      // Read-back word
	output reg         rd_valid_ff,     // Read-back word strobe
	input  wire        selfcfg_fail,    // Self-configuration failed
	input  wire        conversion_start_pin, // Conversion start, asynchronous
	input  wire        pair_done,       // Datapath finished the issued pair
	output reg         conv_go_ff,      // Convert one pair now
	output reg  [3:0]  pick_a_ff,       // ADC A input pick of the pair
	output reg  [3:0]  pick_b_ff,       // ADC B input pick of the pair
	output reg  [1:0]  span_a_ff,       // ADC A span: 0 10 V, 1 5 V, 2 2.5 V
	output reg  [1:0]  span_b_ff,       // ADC B span, same coding
	output reg         iftest_ff,       // Fixed self-test words replace results
	output reg  [15:0] fixed_a_ff,      // Fixed result word for ADC A
	output reg  [15:0] fixed_b_ff,      // Fixed result word for ADC B
	output reg         status_req_ff,   // Append the status word now
	output reg  [7:0]  samples_ff,      // Samples per channel, 1 when off
	output reg         busy_ff          // Frame of conversions under way
);

	localparam ST_IDLE  = 3'd0;
	localparam ST_FETCH = 3'd1;
	localparam ST_LOAD  = 3'd2;
	localparam ST_ISSUE = 3'd3;
	localparam ST_WAIT  = 3'd4;
	localparam ST_STAT  = 3'd5;

	reg  [7:0] cfg_ff;
	reg  [7:0] chan_ff;
	reg  [7:0] rng_a_lo_ff;
	reg  [7:0] rng_a_hi_ff;
	reg  [7:0] rng_b_lo_ff;
	reg  [7:0] rng_b_hi_ff;
	reg        cs_meta_ff;
	reg        cs_sync_ff;
	reg        cs_prev_ff;
	reg  [2:0] state_ff;
	reg  [2:0] nxt_state;
	reg  [4:0] level_ff;
	reg  [4:0] nxt_level;
	reg        last_ff;
	reg        rd_pend_ff;
	reg  [5:0] rd_sel_ff;
	reg  [3:0] done_a_ff;
	reg  [3:0] done_b_ff;
	reg  [15:0] nxt_rd_word;
	reg  [7:0] rd_body;
	reg  [8:0] stack_copy_ff;
	reg  [8:0] shadow_ff [0:`ADCC_STK_DEPTH-1];
	integer    k;

	wire       is_write;
	wire       to_stack;
	wire [4:0] sel_lo;
	wire       cfg_wr;
	wire       start_edge;
	wire       seq_on;
	wire       burst_on;
	wire       append_on;
	wire [8:0] host_entry;
	wire [8:0] seq_entry;
	wire [2:0] os_code;

	// Command word split
	assign is_write = cmd_word[`ADCC_CMD_WRITE];
	assign to_stack = cmd_word[`ADCC_CMD_STACK];
	assign sel_lo   = cmd_word[`ADCC_CMD_SEL_HI-1:`ADCC_CMD_SEL_LO];
	assign cfg_wr   = cmd_valid & is_write & ~to_stack;

	// Mode bits
	assign seq_on    = cfg_ff[`ADCC_CFG_SEQ];
	assign burst_on  = cfg_ff[`ADCC_CFG_BURST];
	// Either append bit alone enables the trailing status word
	assign append_on = cfg_ff[`ADCC_CFG_STATUS] | cfg_ff[`ADCC_CFG_CHECK];
	assign os_code   = cfg_ff[`ADCC_CFG_OS_HI:`ADCC_CFG_OS_LO];

	// Range field of one input out of a pair of range registers
	function [1:0] field_of;
		input [7:0] lo;
		input [7:0] hi;
		input [3:0] pick;
		reg   [7:0] r;
		begin
			r = pick[2] ? hi : lo;
			case (pick[1:0])
				2'd0:    field_of = r[1:0];
				2'd1:    field_of = r[3:2];
				2'd2:    field_of = r[5:4];
				default: field_of = r[7:6];
			endcase
			// Monitors and self-test have no programmable range
			if (pick[3])
				field_of = 2'h3;
		end
	endfunction

	// Range code to span: 00 and 11 share the widest span
	function [1:0] span_of;
		input [1:0] code;
		begin
			case (code)
				2'b01:   span_of = 2'd2;
				2'b10:   span_of = 2'd1;
				default: span_of = 2'd0;
			endcase
		end
	endfunction

	// Oversampling code to samples per channel
	function [7:0] samples_of;
		input [2:0] code;
		begin
			samples_of = 8'h01 << code;
		end
	endfunction

	// Stack store shared by host access and the sequencer
	assign host_entry = cmd_word[`ADCC_CMD_DATA_HI:0];

	adcc_stack_mem #(
		.DEPTH (`ADCC_STK_DEPTH),
		.AW    (`ADCC_STK_AW)
	) u_stack (
		.clock    (clock),
		.reset_n  (reset_n),
		.wr_en    (cmd_valid & is_write & to_stack),
		.wr_addr  (sel_lo),
		.wr_data  (host_entry),
		.rd0_addr (sel_lo),
		.rd0_data (),
		.rd1_addr (level_ff),
		.rd1_data (seq_entry)
	);

	// The store's host port stays open: host reads come from the shadow
	// below, so a host read never steals a cycle from a sequencer fetch
	// The shadow costs a second copy of the levels; latency was preferred

	// Writable registers; writes to unmapped selects are dropped
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cfg_ff      <= `ADCC_RST_CONFIG;
			chan_ff     <= `ADCC_RST_CHANNEL;
			rng_a_lo_ff <= `ADCC_RST_RANGE;
			rng_a_hi_ff <= `ADCC_RST_RANGE;
			rng_b_lo_ff <= `ADCC_RST_RANGE;
			rng_b_hi_ff <= `ADCC_RST_RANGE;
		end else if (cfg_wr) begin
			case (sel_lo)
				// Flag position is read-only, its stored bit stays zero
				`ADCC_SEL_CONFIG:     cfg_ff <= {1'b0, cmd_word[6:0]};
				`ADCC_SEL_CHANNEL:    chan_ff <= cmd_word[7:0];
				`ADCC_SEL_RANGE_A_LO: rng_a_lo_ff <= cmd_word[7:0];
				`ADCC_SEL_RANGE_A_HI: rng_a_hi_ff <= cmd_word[7:0];
				`ADCC_SEL_RANGE_B_LO: rng_b_lo_ff <= cmd_word[7:0];
				`ADCC_SEL_RANGE_B_HI: rng_b_hi_ff <= cmd_word[7:0];
				default:              cfg_ff <= cfg_ff;
			endcase
		end
	end

	// Read body per select; addressing bits echo back in 15..9, except for the status select
	always @* begin
		case (rd_sel_ff[4:0])
			`ADCC_SEL_CONFIG:     rd_body = {selfcfg_fail, cfg_ff[6:0]};
			`ADCC_SEL_CHANNEL:    rd_body = chan_ff;
			`ADCC_SEL_RANGE_A_LO: rd_body = rng_a_lo_ff;
			`ADCC_SEL_RANGE_A_HI: rd_body = rng_a_hi_ff;
			`ADCC_SEL_RANGE_B_LO: rd_body = rng_b_lo_ff;
			`ADCC_SEL_RANGE_B_HI: rd_body = rng_b_hi_ff;
			default:              rd_body = 8'h00;
		endcase
		nxt_rd_word = {1'b0, rd_sel_ff, 1'b0, rd_body};
		if (rd_sel_ff[5])
			nxt_rd_word = {1'b0, rd_sel_ff, stack_copy_ff};
		else if (rd_sel_ff[4:0] == `ADCC_SEL_STATUS)
			nxt_rd_word = {done_a_ff, done_b_ff, 8'h00};
	end

	// Shadow mirrors the stack so host reads never disturb the sequencer
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			for (k = 0; k < `ADCC_STK_DEPTH; k = k + 1)
				shadow_ff[k] <= (k < `ADCC_STK_PRESET) ?
					{(k == `ADCC_STK_PRESET - 1), k[3:0], k[3:0]} : 9'h000;
			stack_copy_ff <= 9'h000;
		end else begin
			if (cmd_valid & is_write & to_stack)
				shadow_ff[sel_lo] <= host_entry;
			stack_copy_ff <= shadow_ff[sel_lo];
		end
	end

	// Read request: a zero write flag answers two cycles later
	// Back-to-back reads are allowed; each gets its own answer cycle
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rd_pend_ff  <= 1'b0;
			rd_sel_ff   <= 6'h00;
			rd_valid_ff <= 1'b0;
			rd_word_ff  <= 16'h0000;
		end else begin
			rd_pend_ff  <= cmd_valid & ~is_write;
			if (cmd_valid & ~is_write)
				rd_sel_ff <= cmd_word[`ADCC_CMD_SEL_HI:`ADCC_CMD_SEL_LO];
			rd_valid_ff <= rd_pend_ff;
			if (rd_pend_ff)
				rd_word_ff <= nxt_rd_word;
		end
	end

	// Start pin synchroniser; edge taken past the second stage
	// Reset level equals the idle pin level, so no false edge after reset
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cs_meta_ff <= 1'b0;
			cs_sync_ff <= 1'b0;
			cs_prev_ff <= 1'b0;
		end else begin
			cs_meta_ff <= conversion_start_pin;
			cs_sync_ff <= cs_meta_ff;
			cs_prev_ff <= cs_sync_ff;
		end
	end
	assign start_edge = cs_sync_ff & ~cs_prev_ff;

	// Scheduler next state; starts during a frame are ignored
	// The host must wait for busy to fall before the next start pulse
	always @* begin
		nxt_state = state_ff;
		nxt_level = level_ff;
		case (state_ff)
			ST_IDLE: begin
				if (start_edge)
					nxt_state = seq_on ? ST_FETCH : ST_ISSUE;
			end
			ST_FETCH: nxt_state = ST_LOAD;
			ST_LOAD:  nxt_state = ST_ISSUE;
			ST_ISSUE: nxt_state = ST_WAIT;
			ST_WAIT: begin
				if (pair_done) begin
					if (seq_on)
						nxt_level = last_ff ? 5'd0 : level_ff + 5'd1;
					if (seq_on & burst_on & ~last_ff)
						nxt_state = ST_FETCH;
					else if (append_on)
						nxt_state = ST_STAT;
					else
						nxt_state = ST_IDLE;
				end
			end
			ST_STAT:  nxt_state = ST_IDLE;
			default:  nxt_state = ST_IDLE;
		endcase
	end

	// Scheduler registers and pair outputs
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_ff      <= ST_IDLE;
			level_ff      <= 5'd0;
			last_ff       <= 1'b0;
			conv_go_ff    <= 1'b0;
			pick_a_ff     <= 4'h0;
			pick_b_ff     <= 4'h0;
			status_req_ff <= 1'b0;
			busy_ff       <= 1'b0;
			done_a_ff     <= 4'h0;
			done_b_ff     <= 4'h0;
		end else begin
			state_ff      <= nxt_state;
			level_ff      <= nxt_level;
			conv_go_ff    <= (nxt_state == ST_ISSUE);
			status_req_ff <= (nxt_state == ST_STAT);
			busy_ff       <= (nxt_state != ST_IDLE);
			if (state_ff == ST_IDLE && start_edge && !seq_on) begin
				pick_a_ff <= chan_ff[3:0];
				pick_b_ff <= chan_ff[7:4];
				last_ff   <= 1'b1;
			end else if (state_ff == ST_LOAD) begin
				pick_a_ff <= seq_entry[3:0];
				pick_b_ff <= seq_entry[7:4];
				last_ff   <= seq_entry[`ADCC_STK_LAST];
			end
			if (state_ff == ST_WAIT && pair_done) begin
				done_a_ff <= pick_a_ff;
				done_b_ff <= pick_b_ff;
			end
		end
	end

	// Per-pair range, self-test words and oversampling
	// Spans and the self-test flag follow the picks one cycle later
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			span_a_ff  <= 2'd0;
			span_b_ff  <= 2'd0;
			iftest_ff  <= 1'b0;
			fixed_a_ff <= 16'h0000;
			fixed_b_ff <= 16'h0000;
			samples_ff <= 8'h01;
		end else begin
			span_a_ff  <= span_of(field_of(rng_a_lo_ff, rng_a_hi_ff, pick_a_ff));
			span_b_ff  <= span_of(field_of(rng_b_lo_ff, rng_b_hi_ff, pick_b_ff));
			// Fixed words prove the digital interface independent of the ADCs
			iftest_ff  <= (pick_a_ff == `ADCC_PICK_IFTEST) |
			              (pick_b_ff == `ADCC_PICK_IFTEST);
			fixed_a_ff <= `ADCC_IFTEST_A;
			fixed_b_ff <= `ADCC_IFTEST_B;
			samples_ff <= samples_of(os_code);
		end
	end

endmodule // adcc_config_bank

// >>> common/adcc_consts.vh
// Constants of the software configuration register bank.
// Assumes inclusion by the bank and its stack memory only.
`ifndef ADCC_CONSTS_VH
`define ADCC_CONSTS_VH

// Command word fields
`define ADCC_CMD_WRITE      15
`define ADCC_CMD_SEL_HI     14
`define ADCC_CMD_SEL_LO     9
`define ADCC_CMD_STACK      14
`define ADCC_CMD_DATA_HI    8

// Register select codes (low five select bits)
`define ADCC_SEL_CONFIG     5'h02
`define ADCC_SEL_CHANNEL    5'h03
`define ADCC_SEL_RANGE_A_LO 5'h04
`define ADCC_SEL_RANGE_A_HI 5'h05
`define ADCC_SEL_RANGE_B_LO 5'h06
`define ADCC_SEL_RANGE_B_HI 5'h07
`define ADCC_SEL_STATUS     5'h08

// Configuration word bit positions
`define ADCC_CFG_SELFTEST   7
`define ADCC_CFG_BURST      6
`define ADCC_CFG_SEQ        5
`define ADCC_CFG_OS_HI      4
`define ADCC_CFG_OS_LO      2
`define ADCC_CFG_STATUS     1
`define ADCC_CFG_CHECK      0

// Reset values
`define ADCC_RST_CONFIG     8'h00
`define ADCC_RST_CHANNEL    8'h00
`define ADCC_RST_RANGE      8'hFF

// Channel pick codes
`define ADCC_PICK_SUPPLY    4'h8
`define ADCC_PICK_REGMON    4'h9
`define ADCC_PICK_IFTEST    4'hB

// Interface self-test words
`define ADCC_IFTEST_A       16'hAAAA
`define ADCC_IFTEST_B       16'h5555

// Stack entry layout: last flag, ADC B pick, ADC A pick
`define ADCC_STK_W          9
`define ADCC_STK_LAST       8
`define ADCC_STK_DEPTH      32
`define ADCC_STK_AW         5
`define ADCC_STK_PRESET     8

`endif

// >>> hw/adcc_stack_mem.v
// Sequencer stack store: one write port, two registered read ports.
// Assumes the bank writes and reads it on the same clock.
`timescale 1ns/1ps
`include "adcc_consts.vh"

module adcc_stack_mem #(
	parameter DEPTH = `ADCC_STK_DEPTH,
	parameter AW    = `ADCC_STK_AW
) (
	input  wire                   clock,    // System clock
	input  wire                   reset_n,  // Async reset, active low
	input  wire                   wr_en,    // Write strobe
	input  wire [AW-1:0]          wr_addr,  // Write level
	input  wire [`ADCC_STK_W-1:0] wr_data,  // Write entry
	input  wire [AW-1:0]          rd0_addr, // Host read level
	output reg  [`ADCC_STK_W-1:0] rd0_data, // Host read entry
	input  wire [AW-1:0]          rd1_addr, // Sequencer read level
	output reg  [`ADCC_STK_W-1:0] rd1_data  // Sequencer read entry
);

	reg [`ADCC_STK_W-1:0] mem_ff [0:DEPTH-1];
	integer               i;

	// Preset walks pairs 0..7 and loops; the rest reset to zero
	function [`ADCC_STK_W-1:0] preset_of;
		input integer lvl;
		reg   [3:0]   p;
		begin
			p = lvl[3:0];
			if (lvl < `ADCC_STK_PRESET)
				preset_of = {(lvl == `ADCC_STK_PRESET - 1), p, p};
			else
				preset_of = {`ADCC_STK_W{1'b0}};
		end
	endfunction

	// Storage with reset preset
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			for (i = 0; i < DEPTH; i = i + 1)
				mem_ff[i] <= preset_of(i);
		end else if (wr_en) begin
			mem_ff[wr_addr] <= wr_data;
		end
	end

	// Read data come out of registers
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rd0_data <= {`ADCC_STK_W{1'b0}};
			rd1_data <= {`ADCC_STK_W{1'b0}};
		end else begin
			rd0_data <= mem_ff[rd0_addr];
			rd1_data <= mem_ff[rd1_addr];
		end
	end

endmodule // adcc_stack_mem

// >>> test/adcc_config_bank_chk.sv
// Port checker for the configuration bank.
// Assumes a bind onto adcc_config_bank and a single clock domain.
`timescale 1ns/1ps
module adcc_config_bank_chk (
	input wire        clock,         // Clock
	input wire        reset_n,       // Reset, active low
	input wire        cmd_valid,     // Command strobe
	input wire [15:0] cmd_word,      // Command word
	input wire [15:0] rd_word_ff,    // Read answer
	input wire        rd_valid_ff,   // Answer strobe
	input wire        selfcfg_fail,  // Self-test result
	input wire        pair_done,     // Pair finished
	input wire        conv_go_ff,    // Pair issue
	input wire [3:0]  pick_a_ff,     // ADC A pick
	input wire [3:0]  pick_b_ff,     // ADC B pick
	input wire        iftest_ff,     // Fixed words on
	input wire        status_req_ff, // Status append
	input wire [7:0]  samples_ff     // Samples per channel
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	// Reads answer two cycles on; writes stay silent
	property p_rd_lat; cmd_valid && !cmd_word[15] |-> ##2 rd_valid_ff; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read unanswered");
	property p_wr_quiet; cmd_valid && cmd_word[15] |-> ##2 !rd_valid_ff; endproperty
	a_wr_quiet: assert property (p_wr_quiet) else $error("write answered");
	// Answers carry the select they were asked with, status excepted
	property p_rd_addr;
		rd_valid_ff && $past(cmd_word[14:9], 2) != 6'h08
			|-> rd_word_ff[15:9] == {1'b0, $past(cmd_word[14:9], 2)};
	endproperty
	a_rd_addr: assert property (p_rd_addr) else $error("answer address");
	property p_selftest_error_flag; rd_valid_ff && $past(cmd_word[14:9], 2) == 6'h02
		|-> rd_word_ff[7] == selfcfg_fail; endproperty
	a_selftest_error_flag: assert property (p_selftest_error_flag) else $error("self-test flag");
	property p_os; cmd_valid && cmd_word[15:9] == 7'h42
		|-> ##3 samples_ff == (8'h01 << $past(cmd_word[4:2], 3)); endproperty
	a_os: assert property (p_os) else $error("sample count");
	// Pair issue and its side outputs
	property p_go_one; conv_go_ff |=> !conv_go_ff [*2]; endproperty
	a_go_one: assert property (p_go_one) else $error("issue not a pulse");
	property p_iftest; conv_go_ff |=> iftest_ff == (pick_a_ff == 4'hB || pick_b_ff == 4'hB);
	endproperty
	a_iftest: assert property (p_iftest) else $error("self-test pick");
	property p_status; status_req_ff |-> $past(pair_done) && !conv_go_ff; endproperty
	a_status: assert property (p_status) else $error("status timing");
	c_read: cover property (rd_valid_ff);
	c_status: cover property (status_req_ff);
	c_iftest: cover property (conv_go_ff ##1 iftest_ff);
endmodule // adcc_config_bank_chk

// >>> test/adcc_host_model.sv
// Host controller and datapath stand-in facing the bank.
// Assumes the bench calls its tasks one at a time, 1 ns after rising edges.
`timescale 1ns/1ps
module adcc_host_model (
	input  wire        clock,     // System clock
	input  wire        conv_go,   // Pair issue from the bank
	output reg         cmd_valid = 1'b0,     // Command strobe
	output reg  [15:0] cmd_word  = 16'h0000, // Command word
	output reg         start_pin = 1'b0,     // Conversion start
	output reg         pair_done = 1'b0      // Pair finished
);
	logic [15:0] exp_rd[$]; // Expected read answers, oldest first
	bit          slow = 0;  // Datapath answers late when set
	int          cnt = 0;
	// One word per cycle; a read notes its expected answer
	task cmd(input logic [15:0] w, input logic [15:0] exp);
		cmd_valid = 1;
		cmd_word = w;
		if (!w[15]) exp_rd.push_back(exp);
		@(posedge clock);
		#1;
	endtask
	// Released bus shows the inverse of the bus word; a second call in a row flips it back
	task idle(input int n);
		cmd_valid = 0;
		cmd_word = ~cmd_word;
		repeat (n) begin
			@(posedge clock);
			#1;
		end
	endtask
	// Held over three edges so the synchroniser cannot miss it
	task start;
		start_pin = 1;
		repeat (3) begin
			@(posedge clock);
			#1;
		end
		start_pin = 0;
	endtask
	// Finishes each issued pair, promptly or late
	always @(posedge clock) begin
		pair_done <= #1 (cnt == 1);
		cnt <= conv_go ? (slow ? 8 : 2) : (cnt != 0 ? cnt - 1 : 0);
	end
endmodule // adcc_host_model

// >>> test/tb_adcc_config_bank.sv
// Self-checking bench of the configuration bank.
// Assumes the host model drives commands and start; checker bound below.
`timescale 1ns/1ps
module tb_adcc_config_bank;
	logic        clock, reset_n, selfcfg_fail, span_chk = 1'b0;
	wire         cmd_valid, start_pin, pair_done, conv_go_ff, rd_valid_ff;
	wire         iftest_ff, status_req_ff, busy_ff;
	wire  [15:0] cmd_word, rd_word_ff, fixed_a_ff, fixed_b_ff;
	wire  [7:0]  samples_ff;
	wire  [3:0]  pick_a_ff, pick_b_ff;
	wire  [1:0]  span_a_ff, span_b_ff;
	int          errors = 0, tests_run = 0, st_seen = 0, go_seen = 0;
	logic [15:0] exp_pk[$], cur;
	logic [7:0]  rng[0:3]; // Range registers as the host set them
	adcc_host_model host_u (.clock(clock), .conv_go(conv_go_ff), .cmd_valid(cmd_valid),
		.cmd_word(cmd_word), .start_pin(start_pin), .pair_done(pair_done));
	adcc_config_bank dut_u (.clock(clock), .reset_n(reset_n), .cmd_valid(cmd_valid),
		.cmd_word(cmd_word), .rd_word_ff(rd_word_ff), .rd_valid_ff(rd_valid_ff),
		.selfcfg_fail(selfcfg_fail), .conversion_start_pin(start_pin),
		.pair_done(pair_done), .conv_go_ff(conv_go_ff), .pick_a_ff(pick_a_ff),
		.pick_b_ff(pick_b_ff), .span_a_ff(span_a_ff), .span_b_ff(span_b_ff),
		.iftest_ff(iftest_ff), .fixed_a_ff(fixed_a_ff), .fixed_b_ff(fixed_b_ff),
		.status_req_ff(status_req_ff), .samples_ff(samples_ff), .busy_ff(busy_ff));
	initial begin
		clock = 0;
		forever #4 clock = ~clock;
	end
	task chk_word(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task chk_cnt(input int got, input int exp);
		chk_word(got[15:0], exp[15:0]);
	endtask
	task end_sim;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	function logic [1:0] sp(input logic [1:0] c);
		sp = c == 2'b01 ? 2'h2 : (c == 2'b10 ? 2'h1 : 2'h0);
	endfunction
	// Expected issue: self-test flag, span valid flag, spans, B pick, A pick
	function logic [15:0] pk(input logic [3:0] a, input logic [3:0] b);
		pk = {2'h0, a == 4'hB || b == 4'hB, a < 8 && b < 8,
			sp(rng[{1'b1, b[2]}][{b[1:0], 1'b0} +: 2]),
			sp(rng[{1'b0, a[2]}][{a[1:0], 1'b0} +: 2]), b, a};
	endfunction
	task wr(input logic [5:0] s, input logic [8:0] d);
		host_u.cmd({1'b1, s, d}, 16'h0000);
	endtask
	task rd(input logic [5:0] s, input logic [8:0] d);
		host_u.cmd({1'b0, s, 9'h000}, {1'b0, s, d});
	endtask
	task run(input int pairs, input int st);
		int n;
		for (n = 0; n < 400 && (go_seen == 0 || busy_ff !== 1'b0); n++) begin
			@(posedge clock);
			#1;
		end
		if (n == 400) begin
			errors++;
			$display("ERROR %0t conversion hung", $time);
			end_sim();
		end
		host_u.idle(2);
		chk_cnt(go_seen, pairs);
		chk_cnt(st_seen, st);
		go_seen = 0;
		st_seen = 0;
	endtask
	// Answers are compared against the oldest note as they appear
	always @(negedge clock) begin
		if (span_chk === 1'b1) begin
			if (cur[12]) chk_word({12'h0, span_b_ff, span_a_ff}, {12'h0, cur[11:8]});
			chk_word({15'h0, iftest_ff}, {15'h0, cur[13]});
			if (cur[13]) chk_word(fixed_a_ff, 16'hAAAA);
			if (cur[13]) chk_word(fixed_b_ff, 16'h5555);
		end
		span_chk = 0;
		if (rd_valid_ff === 1'b1)
			chk_word(rd_word_ff, host_u.exp_rd.size() ? host_u.exp_rd.pop_front() : 16'hXXXX);
		if (conv_go_ff === 1'b1) begin
			go_seen++;
			cur = exp_pk.size() ? exp_pk.pop_front() : 16'hXXXX;
			chk_word({8'h0, pick_b_ff, pick_a_ff}, {8'h0, cur[7:0]});
			span_chk = 1;
		end
		if (status_req_ff === 1'b1) st_seen++;
	end
	initial begin
		int i;
		logic [3:0] a, b;
		logic [7:0] d;
		i = $urandom(32'h6058);
		selfcfg_fail = 0;
		reset_n = 0;
		for (i = 0; i < 4; i++) rng[i] = 8'hFF;
		repeat (8) @(posedge clock);
		#1 reset_n = 1;
		rd(6'h02, 9'h000);
		rd(6'h03, 9'h000);
		for (i = 4; i < 8; i++) rd(i[5:0], 9'h0FF);
		rd(6'h01, 9'h000);
		rd(6'h09, 9'h000);
		host_u.idle(3);
		selfcfg_fail = 1;
		host_u.idle(3);
		wr(6'h02, 9'h080);
		rd(6'h02, 9'h080);
		host_u.idle(3);
		selfcfg_fail = 0;
		host_u.idle(3);
		rd(6'h02, 9'h000);
		// Every oversampling code with random mode bits
		for (i = 0; i < 8; i++) begin
			d = {1'b0, 2'($urandom), i[2:0], 2'($urandom)};
			wr(6'h02, {1'b0, d});
			host_u.idle(3);
			chk_word({8'h00, samples_ff}, 16'h0001 << i[2:0]);
			rd(6'h02, {1'b0, d});
		end
		for (i = 0; i < 4; i++) begin
			rng[i] = 8'($urandom);
			wr(6'h04 + i[5:0], {1'b0, rng[i]});
		end
		for (i = 0; i < 4; i++) rd(6'h04 + i[5:0], {1'b0, rng[i]});
		// Manual pairs: inputs, monitors, self-test, each append setting
		for (i = 0; i < 11; i++) begin
			a = i < 8 ? i[3:0] : (i == 8 ? 4'h8 : (i == 9 ? 4'h9 : 4'hB));
			b = i < 8 ? 4'($urandom % 8) : (i == 10 ? 4'hB : 4'h1 - i[3:0]);
			wr(6'h02, {7'h00, i[1:0]});
			wr(6'h03, {1'b0, b, a});
			rd(6'h03, {1'b0, b, a});
			exp_pk.push_back(pk(a, b));
			host_u.idle(1);
			host_u.slow = i[0];
			host_u.start();
			if (i == 3) begin
				host_u.idle(2);
				host_u.start();
			end
			run(1, i[1] | i[0]);
			host_u.cmd(16'h1000, {a, b, 8'h00});
		end
		host_u.slow = 0;
		// Sequencer burst through a shortened stack, then single steps
		a = 4'($urandom % 8);
		b = 4'($urandom % 8);
		wr(6'h20, {1'b0, b, a});
		wr(6'h23, {1'b1, 8'h33});
		rd(6'h20, {1'b0, b, a});
		wr(6'h02, 9'h061);
		exp_pk.push_back(pk(a, b));
		for (i = 1; i < 4; i++) exp_pk.push_back(pk(i[3:0], i[3:0]));
		host_u.idle(1);
		host_u.start();
		run(4, 1);
		wr(6'h02, 9'h020);
		exp_pk.push_back(pk(a, b));
		exp_pk.push_back(pk(4'h1, 4'h1));
		for (i = 0; i < 2; i++) begin
			host_u.idle(1);
			host_u.start();
			run(1, 0);
		end
		// Second reset in mid-run restores the ranges
		reset_n = 0;
		host_u.idle(2);
		reset_n = 1;
		for (i = 4; i < 8; i++) rd(i[5:0], 9'h0FF);
		rd(6'h23, 9'h033);
		rd(6'h27, 9'h177);
		host_u.idle(4);
		chk_cnt(exp_pk.size() + host_u.exp_rd.size(), 0);
		end_sim();
	end
endmodule // tb_adcc_config_bank
bind adcc_config_bank adcc_config_bank_chk chk_u (.clock(clock), .reset_n(reset_n),
	.cmd_valid(cmd_valid), .cmd_word(cmd_word), .rd_word_ff(rd_word_ff),
	.rd_valid_ff(rd_valid_ff), .selfcfg_fail(selfcfg_fail), .pair_done(pair_done),
	.conv_go_ff(conv_go_ff), .pick_a_ff(pick_a_ff), .pick_b_ff(pick_b_ff),
	.iftest_ff(iftest_ff), .status_req_ff(status_req_ff), .samples_ff(samples_ff));
